//--- rtl/afr_pkg.sv
/*
 * Shared constants and types for the amplifier-chain configuration bank:
 * register offsets, writable masks, field positions, decode codes and
 * the packed carriers used at the block ports.
 * Assumes an 8-bit register address and 16-bit register data.
 */
package afr_pkg;

    // Bus and map geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int NREG = 12;
    localparam int NCH = 16;
    localparam int PH_W = 4;
    localparam int PH_PER_REG = 4;

    typedef logic [ADDR_W-1:0] afr_addr_t;
    typedef logic [DATA_W-1:0] afr_word_t;
    typedef logic signed [11:0] afr_dly_ps_t;

    // Register offsets
    localparam afr_addr_t ADDR_OUT_DELAY = 8'h43;
    localparam afr_addr_t ADDR_CW_CTRL = 8'hC0;
    localparam afr_addr_t ADDR_MIX_CH1 = 8'hC1;
    localparam afr_addr_t ADDR_MIX_CH5 = 8'hC2;
    localparam afr_addr_t ADDR_MIX_CH9 = 8'hC3;
    localparam afr_addr_t ADDR_MIX_CH13 = 8'hC4;
    localparam afr_addr_t ADDR_CH_PDN = 8'hC5;
    localparam afr_addr_t ADDR_GBL_PWR = 8'hC6;
    localparam afr_addr_t ADDR_FILTER = 8'hC7;
    localparam afr_addr_t ADDR_LOW_PWR = 8'hC8;
    localparam afr_addr_t ADDR_MED_PWR = 8'hCE;
    localparam afr_addr_t ADDR_SW_DIS = 8'hE6;
    localparam afr_addr_t ADDR_CHAIN_FIRST = 8'hC0;
    localparam afr_addr_t ADDR_CHAIN_LAST = 8'hE6;

    // Storage index of each register
    localparam int IDX_OUT_DELAY = 0;
    localparam int IDX_CW_CTRL = 1;
    localparam int IDX_MIX0 = 2;
    localparam int IDX_CH_PDN = 6;
    localparam int IDX_GBL_PWR = 7;
    localparam int IDX_FILTER = 8;
    localparam int IDX_LOW_PWR = 9;
    localparam int IDX_MED_PWR = 10;
    localparam int IDX_SW_DIS = 11;

    localparam afr_addr_t REG_ADDR [NREG] = '{
        ADDR_OUT_DELAY, ADDR_CW_CTRL, ADDR_MIX_CH1, ADDR_MIX_CH5,
        ADDR_MIX_CH9, ADDR_MIX_CH13, ADDR_CH_PDN, ADDR_GBL_PWR,
        ADDR_FILTER, ADDR_LOW_PWR, ADDR_MED_PWR, ADDR_SW_DIS};

    // Writable bits; reserved positions store and read zero
    localparam afr_word_t REG_MASK [NREG] = '{
        16'h001E, 16'h001F, 16'hFFFF, 16'hFFFF,
        16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h000F,
        16'h0F80, 16'h1000, 16'h4000, 16'h001F};

    localparam afr_word_t RESET_WORD = 16'h0000;

    // Field positions
    localparam int DLY_LSB = 1;
    localparam int DLY_W = 4;
    localparam int CW_SEL_BIT = 0;
    localparam int CW_RATIO_LSB = 1;
    localparam int CW_RATIO_W = 2;
    localparam int CLKBUF16_BIT = 3;
    localparam int CLKBUF1_BIT = 4;
    localparam int GBL_W = 4;
    localparam int FILT_LSB = 7;
    localparam int FILT_W = 5;
    localparam int LOW_PWR_BIT = 12;
    localparam int MED_PWR_BIT = 14;
    localparam int SW_DIS_W = 5;

    // Clock ratio codes and their one-hot form {16X, 8X, 4X, 1X}
    localparam logic [1:0] RATIO_16X = 2'h0;
    localparam logic [1:0] RATIO_8X = 2'h1;
    localparam logic [1:0] RATIO_4X = 2'h2;
    localparam logic [1:0] RATIO_1X = 2'h3;
    localparam logic [3:0] ONEHOT_16X = 4'h8;
    localparam logic [3:0] ONEHOT_8X = 4'h4;
    localparam logic [3:0] ONEHOT_4X = 4'h2;
    localparam logic [3:0] ONEHOT_1X = 4'h1;

    // Serial output clock delay step in picoseconds
    localparam afr_dly_ps_t DLY_STEP_PS = 12'sh06E;

    typedef struct packed {
        logic wr;
        logic rd;
        afr_addr_t addr;
        afr_word_t wdata;
    } afr_bus_req_t;

    typedef struct packed {
        logic cw_mode;
        logic time_gain_mode;
        logic fixed_gain_18db;
        logic atten_lpf_disable;
        logic [3:0] ratio_onehot;
        logic single_rate_diff;
        logic sixteen_rate_diff;
    } afr_cw_cfg_t;

    typedef struct packed {
        logic [NREG-1:0][DATA_W-1:0] regs;
        afr_word_t rd_data;
        logic rd_valid;
        afr_cw_cfg_t cw_cfg;
        logic order_err;
    } afr_state_t;

    typedef struct packed {
        afr_dly_ps_t delay_ps;
    } afr_dly_state_t;

endpackage

//--- rtl/afr_clk_delay.sv
/*
 * Serial output clock delay decoder: turns the four-bit two's complement
 * delay code into a signed delay in picoseconds, one register stage.
 * Assumes the code input comes from a flop in the same clock domain.
 */
`timescale 1ns/1ns
`default_nettype none

module afr_clk_delay
    import afr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [3:0] delay_code,
    output afr_pkg::afr_dly_ps_t delay_ps
);

    afr_dly_state_t st_q;
    afr_dly_state_t st_d;

    // Sign-extend the code, then scale by the step size
    always_comb
    begin
        st_d = st_q;
        st_d.delay_ps = afr_dly_ps_t'({{8{delay_code[3]}}, delay_code}) * DLY_STEP_PS;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign delay_ps = st_q.delay_ps;

    // Code F must give minus one step, zero code no delay, code 1 one step
    property p_dly_signed;
        @(posedge ref_clk) disable iff (sys_rst)
        (delay_code == 4'hF) |=> (delay_ps == -DLY_STEP_PS);
    endproperty
    a_dly_signed: assert property (p_dly_signed) else $error("delay code F not -1 step");

    property p_dly_zero_pos;
        @(posedge ref_clk) disable iff (sys_rst)
        (delay_code == 4'h0) ##1 (delay_code == 4'h1) |=> (delay_ps == DLY_STEP_PS) && ($past(delay_ps) == 12'sh000);
    endproperty
    a_dly_zero_pos: assert property (p_dly_zero_pos) else $error("delay codes 0/1 wrong");

endmodule

`default_nettype wire

//--- rtl/afr_regs.sv
/*
 * Configuration register bank for the receive front end: serial output
 * clock delay and the amplifier-chain map (continuous-wave control,
 * mixer phases, power-down, filter, power and switch options).
 * Assumes a host on a plain strobe port in the ref_clk domain and an
 * externally held gain-table write enable level.
 */
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none

//Behaviour
//- Delay code bits 4:1, 110 ps steps
//- Delay code is two's complement signed
//- Chain registers reset to all zero
//- Single-rate buffer bit: 0 CMOS, 1 differential
//- Sixteen-rate buffer bit: 0 differential, 1 CMOS
//- Ratio field 00/01/10/11 is 16X/8X/4X/1X
//- Bit 0 picks time-gain or continuous-wave
//- Mixer phase is N times 22.5 degrees
module afr_regs
    import afr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire afr_pkg::afr_bus_req_t bus_req,
    output afr_pkg::afr_word_t rd_data,
    output logic rd_valid,
    input wire logic gain_table_write_enable,
    output logic [3:0] out_clock_delay_code,
    output afr_pkg::afr_dly_ps_t out_delay_ps,
    output afr_pkg::afr_cw_cfg_t cw_cfg,
    output logic [afr_pkg::NCH-1:0][afr_pkg::PH_W-1:0] mixer_phase_channel,
    output logic [afr_pkg::NCH-1:0] channel_power_down,
    output logic [afr_pkg::GBL_W-1:0] global_power_ctrl,
    output logic [afr_pkg::FILT_W-1:0] filter_cfg,
    output logic low_power_sel,
    output logic medium_power_sel,
    output logic [afr_pkg::SW_DIS_W-1:0] switch_disable,
    output logic order_err
);

    afr_state_t st_q;
    afr_state_t st_d;
    logic in_chain;
    logic [CW_RATIO_W-1:0] ratio_code;
    afr_word_t cw_word;

    // Chain map spans the continuous-wave control to the switch disables
    assign in_chain = (bus_req.addr >= ADDR_CHAIN_FIRST) && (bus_req.addr <= ADDR_CHAIN_LAST);

    // Reset image: all registers zero, decodes already show that zero word
    // Avoids a cycle after reset where neither mode nor any ratio is on
    localparam afr_state_t RST_STATE = '{
        regs: '0,
        rd_data: RESET_WORD,
        rd_valid: 1'b0,
        cw_cfg: '{
            cw_mode: 1'b0,
            time_gain_mode: 1'b1,
            fixed_gain_18db: 1'b0,
            atten_lpf_disable: 1'b0,
            ratio_onehot: ONEHOT_16X,
            single_rate_diff: 1'b0,
            sixteen_rate_diff: 1'b1
        },
        order_err: 1'b0
    };

    // Next-state: bus decode, read capture, mode decode
    always_comb
    begin
        st_d = st_q;
        st_d.rd_valid = bus_req.rd;
        st_d.rd_data = RESET_WORD;
        for (int i = 0; i < NREG; i++)
        begin
            if (bus_req.addr == REG_ADDR[i])
            begin
                // Reserved positions are dropped, not stored
                if (bus_req.wr)
                    st_d.regs[i] = bus_req.wdata & REG_MASK[i];
                if (bus_req.rd)
                    st_d.rd_data = st_q.regs[i];
            end
        end
        // Sticky until reset; the write itself still lands
        if (bus_req.wr && in_chain && gain_table_write_enable)
            st_d.order_err = 1'b1;
        // Decode the control word as it will stand after this edge
        cw_word = st_d.regs[IDX_CW_CTRL];
        ratio_code = cw_word[CW_RATIO_LSB +: CW_RATIO_W];
        st_d.cw_cfg.cw_mode = cw_word[CW_SEL_BIT];
        st_d.cw_cfg.time_gain_mode = !cw_word[CW_SEL_BIT];
        // Gain pinned at 18 dB; attenuator and filter bypassed in CW
        st_d.cw_cfg.fixed_gain_18db = cw_word[CW_SEL_BIT];
        st_d.cw_cfg.atten_lpf_disable = cw_word[CW_SEL_BIT];
        st_d.cw_cfg.single_rate_diff = cw_word[CLKBUF1_BIT];
        // Opposite sense to the single-rate buffer bit
        st_d.cw_cfg.sixteen_rate_diff = !cw_word[CLKBUF16_BIT];
        unique case (ratio_code)
            RATIO_16X: st_d.cw_cfg.ratio_onehot = ONEHOT_16X;
            RATIO_8X: st_d.cw_cfg.ratio_onehot = ONEHOT_8X;
            RATIO_4X: st_d.cw_cfg.ratio_onehot = ONEHOT_4X;
            RATIO_1X: st_d.cw_cfg.ratio_onehot = ONEHOT_1X;
        endcase
    end

    // Synchronous reset clears every register; decodes match the zero word
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            st_q <= RST_STATE;
        else
            st_q <= st_d;
    end

    // Signed picosecond form of the delay, one stage behind the code
    afr_clk_delay u_clk_delay (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .delay_code(out_clock_delay_code),
        .delay_ps(out_delay_ps)
    );

    // Register fields straight out to the analog controls
    assign rd_data = st_q.rd_data;
    assign rd_valid = st_q.rd_valid;
    assign out_clock_delay_code = st_q.regs[IDX_OUT_DELAY][DLY_LSB +: DLY_W];
    assign cw_cfg = st_q.cw_cfg;
    assign channel_power_down = st_q.regs[IDX_CH_PDN];
    assign global_power_ctrl = st_q.regs[IDX_GBL_PWR][GBL_W-1:0];
    assign filter_cfg = st_q.regs[IDX_FILTER][FILT_LSB +: FILT_W];
    assign low_power_sel = st_q.regs[IDX_LOW_PWR][LOW_PWR_BIT];
    assign medium_power_sel = st_q.regs[IDX_MED_PWR][MED_PWR_BIT];
    assign switch_disable = st_q.regs[IDX_SW_DIS][SW_DIS_W-1:0];
    assign order_err = st_q.order_err;

    // Four phase codes per word, channel 1 in the low nibble
    // Code N means N x 22.5 degrees; the analog side does the scaling
    for (genvar g = 0; g < NCH; g++)
    begin : g_phase
        assign mixer_phase_channel[g] =
            st_q.regs[IDX_MIX0 + g / PH_PER_REG][(g % PH_PER_REG) * PH_W +: PH_W];
    end

    // Delay field follows the written bits 4:1
    property p_dly_field;
        @(posedge ref_clk) disable iff (sys_rst)
        (bus_req.wr && bus_req.addr == ADDR_OUT_DELAY)
            |=> (out_clock_delay_code == $past(bus_req.wdata[DLY_LSB +: DLY_W]));
    endproperty
    a_dly_field: assert property (p_dly_field) else $error("delay code not stored");

    // Delay in ps reaches the written code two edges after the write
    property p_dly_ps;
        @(posedge ref_clk) disable iff (sys_rst)
        (bus_req.wr && bus_req.addr == ADDR_OUT_DELAY && bus_req.wdata[DLY_LSB +: DLY_W] == 4'hE)
            ##1 !(bus_req.wr && bus_req.addr == ADDR_OUT_DELAY)
            |=> (out_delay_ps == -(DLY_STEP_PS + DLY_STEP_PS));
    endproperty
    a_dly_ps: assert property (p_dly_ps) else $error("delay code E not -220 ps");

    // After reset every register reads back zero
    property p_reset_zero;
        @(posedge ref_clk)
        sys_rst |=> (st_q.regs == '0) && !order_err && (cw_cfg.ratio_onehot == ONEHOT_16X);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("register not zero after reset");

    property p_clkbuf1;
        @(posedge ref_clk) disable iff (sys_rst)
        (bus_req.wr && bus_req.addr == ADDR_CW_CTRL)
            |=> (cw_cfg.single_rate_diff == $past(bus_req.wdata[CLKBUF1_BIT]));
    endproperty
    a_clkbuf1: assert property (p_clkbuf1) else $error("single-rate buffer select wrong");

    property p_clkbuf16;
        @(posedge ref_clk) disable iff (sys_rst)
        (bus_req.wr && bus_req.addr == ADDR_CW_CTRL)
            |=> (cw_cfg.sixteen_rate_diff != $past(bus_req.wdata[CLKBUF16_BIT]));
    endproperty
    a_clkbuf16: assert property (p_clkbuf16) else $error("sixteen-rate buffer select wrong");

    // Ratio decode is one-hot and maps 00 to 16X, 11 to 1X
    property p_ratio;
        @(posedge ref_clk) disable iff (sys_rst)
        (bus_req.wr && bus_req.addr == ADDR_CW_CTRL)
            |=> $onehot(cw_cfg.ratio_onehot)
                && (($past(bus_req.wdata[CW_RATIO_LSB +: CW_RATIO_W]) == RATIO_16X)
                    == (cw_cfg.ratio_onehot == ONEHOT_16X))
                && (($past(bus_req.wdata[CW_RATIO_LSB +: CW_RATIO_W]) == RATIO_1X)
                    == (cw_cfg.ratio_onehot == ONEHOT_1X));
    endproperty
    a_ratio: assert property (p_ratio) else $error("clock ratio decode wrong");

    // The two modes never overlap; CW forces fixed gain and bypass
    property p_mode_excl;
        @(posedge ref_clk) disable iff (sys_rst)
        (cw_cfg.cw_mode != cw_cfg.time_gain_mode)
            && (cw_cfg.fixed_gain_18db == cw_cfg.cw_mode)
            && (cw_cfg.atten_lpf_disable == cw_cfg.cw_mode)
            && (cw_cfg.cw_mode == st_q.regs[IDX_CW_CTRL][CW_SEL_BIT]);
    endproperty
    a_mode_excl: assert property (p_mode_excl) else $error("mode select inconsistent");

    // Reserved bits of the control word read back as zero
    property p_reserved;
        @(posedge ref_clk) disable iff (sys_rst)
        (bus_req.rd && bus_req.addr == ADDR_CW_CTRL)
            |=> rd_valid && (rd_data[DATA_W-1:CLKBUF1_BIT+1] == '0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

    // Channel 1 and channel 4 phase follow their nibbles
    property p_phase;
        @(posedge ref_clk) disable iff (sys_rst)
        (bus_req.wr && bus_req.addr == ADDR_MIX_CH1)
            |=> (mixer_phase_channel[0] == $past(bus_req.wdata[PH_W-1:0]))
                && (mixer_phase_channel[3] == $past(bus_req.wdata[DATA_W-1 -: PH_W]));
    endproperty
    a_phase: assert property (p_phase) else $error("mixer phase not stored");

    // Chain write with the gain table enabled raises the error flag
    property p_order;
        @(posedge ref_clk) disable iff (sys_rst)
        (bus_req.wr && in_chain && gain_table_write_enable) |=> order_err [*2];
    endproperty
    a_order: assert property (p_order) else $error("order error not held");

    // Read data stand only in the cycle after the strobe
    property p_rd_timing;
        @(posedge ref_clk) disable iff (sys_rst)
        !bus_req.rd |=> !rd_valid && (rd_data == RESET_WORD);
    endproperty
    a_rd_timing: assert property (p_rd_timing) else $error("read data outside its cycle");

    c_cw_entry: cover property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(cw_cfg.cw_mode) ##1 cw_cfg.ratio_onehot == ONEHOT_1X);
    c_neg_delay: cover property (@(posedge ref_clk) disable iff (sys_rst)
        out_delay_ps < 12'sh000);
    c_wr_then_rd: cover property (@(posedge ref_clk) disable iff (sys_rst)
        (bus_req.wr && bus_req.addr == ADDR_MIX_CH13) ##1
        (bus_req.rd && bus_req.addr == ADDR_MIX_CH13));
    c_order_err: cover property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(order_err));

endmodule

`default_nettype wire

//--- test/afr_host_model.sv
/*
 * Host model for the configuration bank: register write and read cycles
 * on the strobe port, and the gain-table write enable level.
 * Assumes one ref_clk domain and a slave that never stalls.
 */
`timescale 1ns/1ns
`default_nettype none

module afr_host_model
    import afr_pkg::*;
(
    input wire logic ref_clk,
    output var afr_pkg::afr_bus_req_t bus_req,
    output var logic gain_table_write_enable,
    input wire afr_pkg::afr_word_t rd_data,
    input wire logic rd_valid
);
    // Idle bus, enable low so chain writes are legal
    initial
    begin
        bus_req = '0;
        gain_table_write_enable = 1'b0;
    end

    // Reserved positions forced to zero unless a test asks for raw data
    function automatic afr_word_t legal(input afr_addr_t a, input afr_word_t d);
        for (int i = 0; i < NREG; i++)
            if (REG_ADDR[i] == a)
                return d & REG_MASK[i];
        return d;
    endfunction

    task automatic set_gte(input logic en);
        @(posedge ref_clk);
        gain_table_write_enable <= en;
    endtask

    // Write then read back the same place with no gap
    task automatic wr_rd(input afr_addr_t a, input afr_word_t d, input logic raw,
                         output afr_word_t q, output logic v);
        afr_word_t wd;
        wd = raw ? d : legal(a, d);
        @(posedge ref_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: wd};
        @(posedge ref_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge ref_clk);
        bus_req <= '0;
        #1;
        q = rd_data;
        v = rd_valid;
    endtask

    task automatic rd(input afr_addr_t a, output afr_word_t q, output logic v);
        @(posedge ref_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge ref_clk);
        bus_req <= '0;
        #1;
        q = rd_data;
        v = rd_valid;
    endtask
endmodule

`default_nettype wire

//--- test/afr_regs_tb_top.sv
/*
 * Self-checking bench for the configuration bank: reset values, delay
 * decode, continuous-wave control decode, mixer phases, masking,
 * unmapped places and the gain-table ordering flag.
 * Assumes the host model drives every bus input.
 */
`timescale 1ns/1ns
`default_nettype none

module afr_regs_tb_top;
    import afr_pkg::*;
    logic ref_clk;
    logic sys_rst;
    afr_bus_req_t bus_req;
    afr_word_t rd_data;
    logic rd_valid;
    logic gain_table_write_enable;
    logic [3:0] out_clock_delay_code;
    afr_dly_ps_t out_delay_ps;
    afr_cw_cfg_t cw_cfg;
    logic [NCH-1:0][PH_W-1:0] mixer_phase_channel;
    logic [NCH-1:0] channel_power_down;
    logic [GBL_W-1:0] global_power_ctrl;
    logic [FILT_W-1:0] filter_cfg;
    logic low_power_sel;
    logic medium_power_sel;
    logic [SW_DIS_W-1:0] switch_disable;
    logic order_err;
    int miscompares = 0;
    int n_compared = 0;
    afr_word_t q;
    logic v;
    logic [4:0] cb;
    int sd;

    afr_regs u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_req(bus_req),
        .rd_data(rd_data), .rd_valid(rd_valid),
        .gain_table_write_enable(gain_table_write_enable),
        .out_clock_delay_code(out_clock_delay_code), .out_delay_ps(out_delay_ps),
        .cw_cfg(cw_cfg), .mixer_phase_channel(mixer_phase_channel),
        .channel_power_down(channel_power_down), .global_power_ctrl(global_power_ctrl),
        .filter_cfg(filter_cfg), .low_power_sel(low_power_sel),
        .medium_power_sel(medium_power_sel), .switch_disable(switch_disable),
        .order_err(order_err));

    afr_host_model u_host (.ref_clk(ref_clk), .bus_req(bus_req),
        .gain_table_write_enable(gain_table_write_enable),
        .rd_data(rd_data), .rd_valid(rd_valid));

    // 100 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Every place reads zero, decodes show the all-zero settings
    task automatic check_reset();
        afr_word_t rq;
        logic rv;
        for (int i = 0; i < NREG; i++)
        begin
            u_host.rd(REG_ADDR[i], rq, rv);
            chk(rv, 1, "read valid");
            chk(rq, 0, "reset value");
        end
        chk(cw_cfg, 10'b0100_1000_01, "reset decode");
        chk({channel_power_down, global_power_ctrl, filter_cfg, low_power_sel,
            medium_power_sel, switch_disable}, 0, "reset fields");
        chk(|mixer_phase_channel, 0, "reset phases");
        chk(out_clock_delay_code, 0, "reset code");
        chk(order_err, 0, "reset flag");
        chk(out_delay_ps, 0, "reset delay");
    endtask

    // Hang guard
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        $display("[FAIL] %0t timeout", $time);
        end_of_test();
    end

    // Main sequence
    initial
    begin
        sys_rst = 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        check_reset();
        // All delay codes, negative half included
        for (int c = 0; c < 16; c++)
        begin
            u_host.wr_rd(ADDR_OUT_DELAY, afr_word_t'(c) << DLY_LSB, 1'b0, q, v);
            chk(q, c << 1, "delay readback");
            chk(out_clock_delay_code, c, "delay code");
            sd = (c > 7) ? c - 16 : c;
            chk(out_delay_ps, afr_dly_ps_t'(sd * 110), "delay ps");
        end
        // Every combination of mode, ratio and buffer bits
        for (int m = 0; m < 32; m++)
        begin
            cb = m[4:0];
            u_host.wr_rd(ADDR_CW_CTRL, afr_word_t'(cb), 1'b0, q, v);
            chk(q, cb, "control readback");
            chk(cw_cfg, {cb[0], ~cb[0], cb[0], cb[0], 4'h8 >> cb[2:1], cb[4], ~cb[3]},
                "control decode");
        end
        // Channel g gets phase code g, so every code 0 to 15 appears
        for (int k = 0; k < 4; k++)
            u_host.wr_rd(REG_ADDR[IDX_MIX0 + k], afr_word_t'(16'h3210 + 16'h4444 * k),
                1'b0, q, v);
        for (int g = 0; g < NCH; g++)
            chk(mixer_phase_channel[g], g, "mixer phase");
        // Ones into reserved places must not stick
        for (int i = 0; i < NREG; i++)
        begin
            u_host.wr_rd(REG_ADDR[i], 16'hFFFF, 1'b1, q, v);
            chk(q, REG_MASK[i], "masked readback");
        end
        chk({channel_power_down, global_power_ctrl, filter_cfg, low_power_sel,
            medium_power_sel, switch_disable}, 32'hFFFF_FFFF, "field outputs");
        // Unmapped places: read zero, write lands nowhere
        u_host.wr_rd(8'hD5, 16'h0000, 1'b1, q, v);
        chk({v, q}, 17'h10000, "unmapped read");
        u_host.rd(ADDR_CH_PDN, q, v);
        chk(q, 16'hFFFF, "no alias");
        // Enable high: non-chain write is fine, chain write flags
        u_host.set_gte(1'b1);
        u_host.wr_rd(ADDR_OUT_DELAY, 16'h0002, 1'b0, q, v);
        chk(order_err, 0, "flag quiet");
        u_host.wr_rd(ADDR_CW_CTRL, 16'h0001, 1'b0, q, v);
        chk({order_err, q}, 17'h10001, "flag set");
        u_host.set_gte(1'b0);
        // Second reset in mid-run clears everything again
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        check_reset();
        end_of_test();
    end
endmodule

`default_nettype wire
